// file: hw/pwm_cfg.svh
`ifndef PWM_CFG_SVH
`define PWM_CFG_SVH
// Register indices on the plain port
`define ADDR_CTRL1     5'h00
`define ADDR_CTRL2     5'h01
`define ADDR_OUT_CTRL  5'h02
`define ADDR_POLARITY  5'h03
`define ADDR_PERIOD    5'h04
`define ADDR_XFER_DIS  5'h05
`define ADDR_IRQ_STAT  5'h06
`define ADDR_IRQ_MASK  5'h07
`define ADDR_BUF_BASE  5'h08
`define ADDR_DUTY_BASE 5'h10
// Control register fields
`define CTRL_CST_BIT   7
`define CTRL_IE_BIT    6
`define CTRL_CMF_BIT   5
`define CTRL_CKS_LO    0
`define CTRL_CKS_HI    2
// Duty register fields
`define DUTY_OTS_BIT   12
`define DUTY_VAL_HI    9
// Reserved bits of buffer registers read as one
`define BUF_RSVD_ONES  16'hEC00
`define PERIOD_RESET   10'h3FF
`endif

// file: hw/pwm_pkg.sv
package pwm_pkg;
  typedef logic [9:0] count_t;
  typedef logic [7:0] byte_t;
  typedef logic [15:0] word_t;
endpackage : pwm_pkg

// file: hw/buffered_dual_group_pwm.sv
`timescale 1ns/1ns
`include "pwm_cfg.svh"
// What this block does
// - Start bit set begins period counting
// - Period match copies buffers, sets match flag
// - Enabled match flag raises interrupt request
// - Period match drives selected output active
// - Duty match drives selected output inactive
// - Polarity bit inverts generated level
// - Counter clears to zero after match
// - Start bit clear halts, outputs inactive
// - Disable bit suppresses buffer-to-duty copy
// - Cleared disable bit resumes copying
// - Write in the match cycle updates buffer and duty
// - Select bit zero first, one second
// - Zero duty gives no active period
// - Disable bits reset to zero
module buffered_dual_group_pwm (
  // Clock and reset
  input  wire logic            core_clk,
  input  wire logic            rst_n,
  // Register port
  input  wire logic [4:0]      reg_addr,
  input  wire pwm_pkg::word_t  reg_wdata,
  input  wire logic            reg_wr,
  input  wire logic            reg_rd,
  output pwm_pkg::word_t       reg_rdata,
  // Pins
  output logic [7:0]           group_one_outputs,
  output logic [7:0]           group_one_oe,
  output logic [7:0]           group_two_outputs,
  output logic [7:0]           group_two_oe,
  // Events
  output logic                 match_dtc_req,
  output logic                 irq
);
  import pwm_pkg::*;

  logic       rst_s1_r;
  logic       rst_s2_r;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end

  byte_t      ctrl_r    [2];
  byte_t      ctrl_nxt  [2];
  byte_t      oe_r;
  byte_t      oe_nxt;
  byte_t      pol_r;
  byte_t      pol_nxt;
  byte_t      xdis_r;
  byte_t      xdis_nxt;
  byte_t      stat_r;
  byte_t      stat_nxt;
  byte_t      mask_r;
  byte_t      mask_nxt;
  count_t     period_r;
  count_t     period_nxt;

  word_t      buf_r     [8];
  word_t      buf_nxt   [8];
  word_t      duty_r    [8];
  word_t      duty_nxt  [8];
  word_t      xfer_val  [8];

  count_t     cnt_r     [2];
  count_t     cnt_nxt   [2];
  logic [7:0] pre_r     [2];
  logic [7:0] pre_nxt   [2];
  logic [7:0] tick_mask [2];
  logic [7:0] lvl_r     [2];
  logic [7:0] lvl_nxt   [2];
  logic [7:0] pin_r     [2];
  logic [7:0] pin_nxt   [2];
  logic       match     [2];
  logic       tick      [2];

  word_t      rdata_r;
  word_t      rdata_nxt;
  logic       wr_hit    [32];

  always_comb begin
    for (int a = 0; a < 32; a++) begin
      wr_hit[a] = reg_wr && (reg_addr == 5'(a));
    end
  end

  // Prescaler count per group
  always_comb begin
    for (int g = 0; g < 2; g++) begin
      pre_nxt[g] = ctrl_r[g][`CTRL_CST_BIT] ? 8'(pre_r[g] + 8'h01) : 8'h00;
    end
  end

  // Tick and match detect per group
  always_comb begin
    for (int g = 0; g < 2; g++) begin
      tick_mask[g] = 8'((9'h001 << ctrl_r[g][`CTRL_CKS_HI:`CTRL_CKS_LO]) - 9'h001);
      tick[g] = ctrl_r[g][`CTRL_CST_BIT] && ((pre_r[g] & tick_mask[g]) == tick_mask[g]);
      match[g] = tick[g] && (cnt_r[g] == period_r);
    end
  end

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      xfer_val[i] = (match[i/4] && !xdis_r[i]) ? buf_r[i] : duty_r[i];
    end
  end

  // Counters per group
  always_comb begin
    for (int g = 0; g < 2; g++) begin
      cnt_nxt[g] = cnt_r[g];
      if (!ctrl_r[g][`CTRL_CST_BIT]) begin
        cnt_nxt[g] = 10'h000;
      end else if (match[g]) begin
        cnt_nxt[g] = 10'h000;
      end else if (tick[g]) begin
        cnt_nxt[g] = count_t'(cnt_r[g] + 10'h001);
      end
    end
  end

  // Output levels per pair
  always_comb begin
    for (int g = 0; g < 2; g++) begin
      lvl_nxt[g] = lvl_r[g];
      for (int p = 0; p < 4; p++) begin
        if (match[g]) begin
          lvl_nxt[g][2*p]   = !xfer_val[4*g+p][`DUTY_OTS_BIT] && (xfer_val[4*g+p][9:0] != 10'h000);
          lvl_nxt[g][2*p+1] = xfer_val[4*g+p][`DUTY_OTS_BIT] && (xfer_val[4*g+p][9:0] != 10'h000);
        end else if (tick[g] && (cnt_r[g] == duty_r[4*g+p][`DUTY_VAL_HI:0])) begin
          lvl_nxt[g][2*p + 32'(duty_r[4*g+p][`DUTY_OTS_BIT])] = 1'b0;
        end
      end
      if (!ctrl_r[g][`CTRL_CST_BIT]) begin
        lvl_nxt[g] = 8'h00;
      end
    end
  end

  always_comb begin
    pin_nxt[0] = lvl_nxt[0] ^ pol_nxt;
    pin_nxt[1] = lvl_nxt[1] ^ pol_nxt;
  end

  // Register writes and flags
  always_comb begin
    oe_nxt = wr_hit[`ADDR_OUT_CTRL] ? reg_wdata[7:0] : oe_r;
    pol_nxt = wr_hit[`ADDR_POLARITY] ? reg_wdata[7:0] : pol_r;
    xdis_nxt = wr_hit[`ADDR_XFER_DIS] ? reg_wdata[7:0] : xdis_r;
    mask_nxt = wr_hit[`ADDR_IRQ_MASK] ? reg_wdata[7:0] : mask_r;
    period_nxt = wr_hit[`ADDR_PERIOD] ? reg_wdata[9:0] : period_r;
    stat_nxt = stat_r & ~(wr_hit[`ADDR_IRQ_STAT] ? reg_wdata[7:0] : 8'h00);
    for (int g = 0; g < 2; g++) begin
      ctrl_nxt[g] = ctrl_r[g];
      if (wr_hit[`ADDR_CTRL1 + g]) begin
        ctrl_nxt[g] = reg_wdata[7:0];
        // Flag clears only by writing zero
        ctrl_nxt[g][`CTRL_CMF_BIT] = ctrl_r[g][`CTRL_CMF_BIT] & reg_wdata[`CTRL_CMF_BIT];
      end
      if (match[g]) begin
        ctrl_nxt[g][`CTRL_CMF_BIT] = 1'b1;
        stat_nxt[g] = 1'b1;
      end
    end
  end

  // Buffer and duty registers
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      buf_nxt[i] = buf_r[i];
      duty_nxt[i] = duty_r[i];
      if (match[i/4] && !xdis_r[i]) begin
        duty_nxt[i] = buf_r[i];
      end
      if (wr_hit[`ADDR_BUF_BASE + i]) begin
        buf_nxt[i] = reg_wdata & ~`BUF_RSVD_ONES;
        if (match[i/4] && !xdis_r[i]) begin
          duty_nxt[i] = reg_wdata & ~`BUF_RSVD_ONES;
        end
      end
    end
  end

  always_comb begin
    rdata_nxt = 16'h0000;
    if (reg_rd) begin
      if (reg_addr >= `ADDR_DUTY_BASE) begin
        rdata_nxt = duty_r[reg_addr[2:0]] | `BUF_RSVD_ONES;
      end else if (reg_addr >= `ADDR_BUF_BASE) begin
        rdata_nxt = buf_r[reg_addr[2:0]] | `BUF_RSVD_ONES;
      end else begin
        unique case (reg_addr[2:0])
          3'h0: rdata_nxt = {8'h00, ctrl_r[0]};
          3'h1: rdata_nxt = {8'h00, ctrl_r[1]};
          3'h2: rdata_nxt = {8'h00, oe_r};
          3'h3: rdata_nxt = {8'h00, pol_r};
          3'h4: rdata_nxt = {6'h00, period_r};
          3'h5: rdata_nxt = {8'h00, xdis_r};
          3'h6: rdata_nxt = {8'h00, stat_r};
          3'h7: rdata_nxt = {8'h00, mask_r};
        endcase
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_s2_r) begin
    if (!rst_s2_r) begin
      pre_r <= '{default: 8'h00};
    end else begin
      pre_r <= pre_nxt;
    end
  end

  always_ff @(posedge core_clk or negedge rst_s2_r) begin
    if (!rst_s2_r) begin
      cnt_r <= '{default: 10'h000};
      lvl_r <= '{default: 8'h00};
      pin_r <= '{default: 8'h00};
    end else begin
      cnt_r <= cnt_nxt;
      lvl_r <= lvl_nxt;
      pin_r <= pin_nxt;
    end
  end

  always_ff @(posedge core_clk or negedge rst_s2_r) begin
    if (!rst_s2_r) begin
      ctrl_r   <= '{default: 8'h00};
      oe_r     <= 8'h00;
      pol_r    <= 8'h00;
      xdis_r   <= 8'h00;
      stat_r   <= 8'h00;
      mask_r   <= 8'h00;
      period_r <= `PERIOD_RESET;
    end else begin
      ctrl_r   <= ctrl_nxt;
      oe_r     <= oe_nxt;
      pol_r    <= pol_nxt;
      xdis_r   <= xdis_nxt;
      stat_r   <= stat_nxt;
      mask_r   <= mask_nxt;
      period_r <= period_nxt;
    end
  end

  always_ff @(posedge core_clk or negedge rst_s2_r) begin
    if (!rst_s2_r) begin
      buf_r  <= '{default: 16'h0000};
      duty_r <= '{default: 16'h0000};
    end else begin
      buf_r  <= buf_nxt;
      duty_r <= duty_nxt;
    end
  end

  always_ff @(posedge core_clk or negedge rst_s2_r) begin
    if (!rst_s2_r) begin
      rdata_r <= 16'h0000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;

  assign group_one_outputs = pin_r[0];
  assign group_two_outputs = pin_r[1];

  assign group_one_oe = oe_r;
  assign group_two_oe = oe_r;

  assign match_dtc_req = (ctrl_r[0][`CTRL_CMF_BIT] & ctrl_r[0][`CTRL_IE_BIT]) |
                         (ctrl_r[1][`CTRL_CMF_BIT] & ctrl_r[1][`CTRL_IE_BIT]);
  assign irq = |(stat_r & mask_r);
endmodule : buffered_dual_group_pwm

// file: dv/pwm_load.sv
`timescale 1ns/1ns
module pwm_load (
  // Clock and measure control
  input  wire logic        core_clk,
  input  wire logic        clr,
  // Group one pins
  input  wire logic [7:0]  pins,
  input  wire logic [7:0]  oe,
  // High time of pair A/B
  output logic      [15:0] hi_a,
  output logic      [15:0] hi_b
);
  always_ff @(posedge core_clk) begin
    hi_a <= clr ? 16'h0000 : hi_a + 16'(pins[0] & oe[0]);
    hi_b <= clr ? 16'h0000 : hi_b + 16'(pins[1] & oe[1]);
  end
endmodule : pwm_load

// file: dv/pwm_props.sv
`timescale 1ns/1ns
module pwm_props import pwm_pkg::*; (
  // Clock, reset, register port
  input wire logic           core_clk,
  input wire logic           rst_n,
  input wire logic [4:0]     reg_addr,
  input wire pwm_pkg::word_t reg_wdata,
  input wire logic           reg_wr,
  input wire logic           reg_rd,
  input wire pwm_pkg::word_t reg_rdata,
  // Pins and events
  input wire logic [7:0]     group_one_outputs,
  input wire logic [7:0]     group_one_oe,
  input wire logic [7:0]     group_two_outputs,
  input wire logic [7:0]     group_two_oe,
  input wire logic           match_dtc_req,
  input wire logic           irq
);
  logic [15:0] pol_r;
  logic [1:0]  run_r, ie_r, mask_r;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pol_r <= 16'h0000;
      run_r <= 2'h0;
      ie_r <= 2'h0;
      mask_r <= 2'h0;
    end else if (reg_wr) begin
      if (reg_addr == 5'h03) pol_r <= reg_wdata;
      if (reg_addr == 5'h07) mask_r <= reg_wdata[1:0];
      if (reg_addr < 5'h02) begin
        run_r[reg_addr[0]] <= reg_wdata[7];
        ie_r[reg_addr[0]] <= reg_wdata[6];
      end
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  property p_oe1; reg_wr && reg_addr == 5'h02 |=> group_one_oe == $past(reg_wdata[7:0]); endproperty
  a_oe1: assert property (p_oe1) else $error("group one enable wrong");
  property p_oe2; reg_wr && reg_addr == 5'h02 |=> group_two_oe == $past(reg_wdata[7:0]); endproperty
  a_oe2: assert property (p_oe2) else $error("group two enable wrong");
  property p_stop1; (!run_r[0] && $stable(pol_r)) [*3] |-> group_one_outputs == pol_r[7:0]; endproperty
  a_stop1: assert property (p_stop1) else $error("group one not idle");
  property p_stop2; (!run_r[1] && $stable(pol_r)) [*3] |-> group_two_outputs == pol_r[7:0]; endproperty
  a_stop2: assert property (p_stop2) else $error("group two not idle");
  property p_irq; (mask_r == 2'h0) [*2] |-> !irq; endproperty
  a_irq: assert property (p_irq) else $error("masked irq high");
  property p_irq_hold; irq && !(reg_wr && reg_addr inside {5'h06, 5'h07}) |=> irq; endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped");
  property p_dtc; (ie_r == 2'h0) [*2] |-> !match_dtc_req; endproperty
  a_dtc: assert property (p_dtc) else $error("request without enable");
  property p_dtc_hold; match_dtc_req && !(reg_wr && reg_addr < 5'h02) |=> match_dtc_req; endproperty
  a_dtc_hold: assert property (p_dtc_hold) else $error("request dropped");
  property p_rsvd; reg_rd && reg_addr inside {[5'h08:5'h17]} |=> reg_rdata[15:13] == 3'h7 && reg_rdata[11:10] == 2'h3;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits not one");
endmodule : pwm_props
bind buffered_dual_group_pwm pwm_props i_pwm_props (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .group_one_outputs(group_one_outputs), .group_one_oe(group_one_oe), .group_two_outputs(group_two_outputs),
  .group_two_oe(group_two_oe), .match_dtc_req(match_dtc_req), .irq(irq));

// file: dv/test_buffered_dual_group_pwm.sv
`timescale 1ns/1ns
module test_buffered_dual_group_pwm;
  import pwm_pkg::*;
  logic        core_clk, rst_n, reg_wr, reg_rd, clr, data_transfer_controller, irq;
  logic [4:0]  reg_addr;
  word_t       reg_wdata, reg_rdata;
  logic [7:0]  g1, oe1, g2, oe2;
  logic [15:0] hi_a, hi_b;
  int          fail_count = 0, samples_checked = 0, cyc = 0;
  buffered_dual_group_pwm i_buffered_dual_group_pwm (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .group_one_outputs(g1),
    .group_one_oe(oe1), .group_two_outputs(g2), .group_two_oe(oe2), .match_dtc_req(data_transfer_controller), .irq(irq));
  pwm_load i_pwm_load (.core_clk(core_clk), .clr(clr), .pins(g1), .oe(oe1), .hi_a(hi_a), .hi_b(hi_b));
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  task automatic test_done;
    if (fail_count == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : test_done
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      fail_count++;
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
    @(posedge core_clk);
  endtask : rd
  task automatic win(input int n, input logic [15:0] ea, input logic [15:0] eb);
    clr <= 1'b1;
    @(posedge core_clk);
    clr <= 1'b0;
    repeat (n) @(posedge core_clk);
    #1 chk(hi_a, ea);
    chk(hi_b, eb);
  endtask : win
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fail_count++;
      test_done();
    end
  end
  initial begin
    {rst_n, reg_wr, reg_rd, clr, reg_addr, reg_wdata} = '0;
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    rd(5'h05, 16'h0000);
    rd(5'h04, 16'h03FF);
    rd(5'h08, 16'hEC00);
    wr(5'h02, 16'h00FF);
    wr(5'h04, 16'h0009);
    wr(5'h08, 16'h0003);
    wr(5'h07, 16'h0001);
    wr(5'h00, 16'h00C0);
    repeat (30) @(posedge core_clk);
    win(40, 16'h0010, 16'h0000);
    chk({15'h0000, irq}, 16'h0001);
    chk({15'h0000, data_transfer_controller}, 16'h0001);
    rd(5'h00, 16'h00E0);
    rd(5'h10, 16'hEC03);
    wr(5'h05, 16'h0001);
    wr(5'h08, 16'h1005);
    repeat (30) @(posedge core_clk);
    rd(5'h10, 16'hEC03);
    wr(5'h05, 16'h0000);
    repeat (20) @(posedge core_clk);
    rd(5'h10, 16'hFC05);
    win(40, 16'h0000, 16'h0018);
    wr(5'h08, 16'h0000);
    repeat (20) @(posedge core_clk);
    win(40, 16'h0000, 16'h0000);
    wr(5'h08, 16'h0004);
    wr(5'h00, 16'h00C1);
    repeat (40) @(posedge core_clk);
    win(80, 16'h0028, 16'h0000);
    wr(5'h03, 16'h0003);
    repeat (2) @(posedge core_clk);
    win(80, 16'h0028, 16'h0050);
    wr(5'h07, 16'h0000);
    #1 chk({15'h0000, irq}, 16'h0000);
    wr(5'h00, 16'h0000);
    repeat (3) @(posedge core_clk);
    #1 chk({8'h00, g1}, 16'h0003);
    chk({8'h00, g2}, 16'h0003);
    wr(5'h06, 16'h0001);
    wr(5'h07, 16'h0001);
    #1 chk({15'h0000, irq}, 16'h0000);
    wr(5'h02, 16'h0000);
    #1 chk({8'h00, oe1}, 16'h0000);
    chk({8'h00, oe2}, 16'h0000);
    test_done();
  end
endmodule : test_buffered_dual_group_pwm
